// [core/iirq_regs.svh]
// Purpose: offsets, field layouts and reset values of the iso interrupt and init registers
// Assumes: byte offsets on an APB bus with 32-bit data, one aligned word per register
// Notes:   the package holds the types; this header holds the numbers
// Notes on behaviour
// - transmit mask holds one enable per iso transmit context for the transmit summary
// - each transmit mask bit aligns with its transmit event flag bit
// - reads at set or clear address of either mask return the mask unchanged
// - receive flag rises when that context's input command completes with interrupt bits
// - receive flag sets on rising edge of context interrupt or write 1 at set
// - receive flag clears only by write 1 at clear; writing 0 changes nothing
// - receive event clear address reads event AND mask; set address reads raw events
// - receive event holds four channel flags in bits 3..0; bits 31..4 read zero
// - receive mask has one enable per channel, aligned, resetting to zero
// - 13-bit bandwidth field, read/write, resets to 1333h, survives bus reset
// - bandwidth field copies into bandwidth-available CSR on any listed reset
// - channels-high register resets all ones, survives bus reset, copies to CSR
// - channels-low register resets all ones, survives bus reset, copies to CSR
// - transmit event register has eight context flags in bits 7..0
`ifndef IIRQ_REGS_SVH
`define IIRQ_REGS_SVH
`define IIRQ_OFF_W        8
`define IIRQ_OFF_TXM_SET  8'h98
`define IIRQ_OFF_TXM_CLR  8'h9c
`define IIRQ_OFF_RXE_SET  8'ha0
`define IIRQ_OFF_RXE_CLR  8'ha4
`define IIRQ_OFF_RXM_SET  8'ha8
`define IIRQ_OFF_RXM_CLR  8'hac
`define IIRQ_OFF_BW       8'hb0
`define IIRQ_OFF_CHAN_HI  8'hb4
`define IIRQ_OFF_CHAN_LO  8'hb8
`define IIRQ_OFF_STS      8'hc0
`define IIRQ_OFF_MSK      8'hc4
`define IIRQ_TX_CTX       8
`define IIRQ_RX_CHN       4
`define IIRQ_BW_W         13
`define IIRQ_BW_RST       13'h1333
`define IIRQ_CHAN_RST     32'hffff_ffff
`define IIRQ_STS_W        3
`define IIRQ_STS_RX       0
`define IIRQ_STS_TX       1
`define IIRQ_STS_LOAD     2
`endif

// [core/iirq_pkg.sv]
// Purpose: shared types of the iso interrupt register slice
// Assumes: 32-bit APB data
// Notes:   numbers live in iirq_regs.svh
package iirq_pkg;
	typedef logic [31:0] iirq_word_t;
	typedef enum {
		SEL_NONE, SEL_TXM_SET, SEL_TXM_CLR, SEL_RXE_SET, SEL_RXE_CLR,
		SEL_RXM_SET, SEL_RXM_CLR, SEL_BW, SEL_CHAN_HI, SEL_CHAN_LO,
		SEL_STS, SEL_MSK
	} iirq_sel_t;
endpackage

// [core/iirq_sc_if.sv]
// Purpose: set/clear write strobes and current value of one bit bank
// Assumes: strobes last one cycle
// Notes:   ctrl side decodes the bus, bank side holds the bits
`timescale 1ns/1ps
interface iirq_sc_if #(
	parameter int W = 8
) ();
	logic         set_we;
	logic         clr_we;
	logic [W-1:0] wdata;
	logic [W-1:0] value;
	modport bank (input set_we, input clr_we, input wdata, output value);
	modport ctrl (output set_we, output clr_we, output wdata, input value);
endinterface // iirq_sc_if

// [core/iirq_sc_bank.sv]
// Purpose: bank of set/clear bits, optionally set by a rising edge of a hardware line
// Assumes: i_hw_level synchronous to i_clk
// Notes:   set wins over clear in the same cycle
`timescale 1ns/1ps
module iirq_sc_bank #(
	parameter int W       = 4,
	parameter bit HW_EDGE = 1'b0
) (
	input  wire logic i_clk,
	input  wire logic i_reset,
	iirq_sc_if.bank   bus,
	input  wire logic [W-1:0] i_hw_level
);
	logic [W-1:0] level_prev_reg;
	logic [W-1:0] bit_reg;
	logic [W-1:0] bit_next;

	if (W < 1) begin : g_bad_w
		$error("iirq_sc_bank: W must be at least 1");
	end

	generate
		for (genvar g = 0; g < W; g++) begin : g_bit
			logic hw_rise;
			assign hw_rise = HW_EDGE & i_hw_level[g] & ~level_prev_reg[g];
			// only a 1 written at clear drops the bit; a set in the same cycle wins
			assign bit_next[g] = (bit_reg[g] & ~(bus.clr_we & bus.wdata[g]))
				| (bus.set_we & bus.wdata[g]) | hw_rise;
			sticky_hold_a: assert property (@(posedge i_clk) disable iff (i_reset)
				$fell(bit_reg[g]) |-> $past(bus.clr_we && bus.wdata[g]))
				else $error("bit dropped without a clear write");
		end
	endgenerate

	// one process owns the whole vector so no bit has two drivers
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			level_prev_reg <= '0;
			bit_reg        <= '0;
		end else begin
			level_prev_reg <= i_hw_level;
			bit_reg        <= bit_next;
		end
	end

	assign bus.value = bit_reg;
endmodule // iirq_sc_bank

// [core/iirq_irq_status.sv]
// Purpose: sticky interrupt status, mask and one level interrupt line
// Assumes: i_clear_bits are the bits the reader actually saw
// Notes:   an event in the clearing cycle survives
`timescale 1ns/1ps
module iirq_irq_status #(
	parameter int W = 3
) (
	input  wire logic         i_clk,
	input  wire logic         i_reset,
	input  wire logic [W-1:0] i_event,
	input  wire logic         i_rd_clear,
	input  wire logic [W-1:0] i_clear_bits,
	input  wire logic         i_mask_we,
	input  wire logic [W-1:0] i_mask_wdata,
	output logic      [W-1:0] o_status,
	output logic      [W-1:0] o_mask,
	output logic              o_irq
);
	logic [W-1:0] status_reg;
	logic [W-1:0] mask_reg;

	if (W < 1) begin : g_bad_w
		$error("iirq_irq_status: W must be at least 1");
	end

	always_ff @(posedge i_clk) begin
		if (i_reset) status_reg <= '0;
		else status_reg <= (status_reg & ~({W{i_rd_clear}} & i_clear_bits)) | i_event;
	end

	always_ff @(posedge i_clk) begin
		if (i_reset) mask_reg <= '0;
		else if (i_mask_we) mask_reg <= i_mask_wdata;
	end

	assign o_status = status_reg;
	assign o_mask   = mask_reg;
	assign o_irq    = |(status_reg & mask_reg);
endmodule // iirq_irq_status

// [core/iirq_top.sv]
// Purpose: iso transmit/receive interrupt masks, receive events and initial bus-management values
// Assumes: APB slave with no wait states; all inputs synchronous to i_ref_clk
// Notes:   reset-type inputs are active-high levels or pulses sampled each clock
`timescale 1ns/1ps
`include "iirq_regs.svh"
module iirq_top #(
	parameter int TX_CTX = `IIRQ_TX_CTX,
	parameter int RX_CHN = `IIRQ_RX_CHN,
	parameter int ADDR_W = `IIRQ_OFF_W
) (
	input  wire logic                 i_ref_clk,
	input  wire logic                 i_reset,
	input  wire logic                 i_soft_reset,
	input  wire logic                 i_global_reset_pin,
	input  wire logic                 i_power_reset_pin,
	input  wire logic                 i_fund_reset,
	input  wire logic                 i_bus_reset,
	input  wire logic                 i_psel,
	input  wire logic                 i_penable,
	input  wire logic                 i_pwrite,
	input  wire logic [ADDR_W-1:0]    i_paddr,
	input  wire iirq_pkg::iirq_word_t i_pwdata,
	output iirq_pkg::iirq_word_t      o_prdata,
	output logic                      o_pready,
	output logic                      o_pslverr,
	input  wire logic [RX_CHN-1:0]    i_rx_ctx_irq,
	input  wire logic [TX_CTX-1:0]    i_tx_event_flags,
	output logic [TX_CTX-1:0]         o_tx_irq_mask,
	output logic                      o_iso_receive_summary_event,
	output logic                      o_iso_transmit_summary_event,
	output logic [`IIRQ_BW_W-1:0]     o_bw_available_csr,
	output iirq_pkg::iirq_word_t      o_chan_avail_hi_csr,
	output iirq_pkg::iirq_word_t      o_chan_avail_lo_csr,
	output logic                      o_csr_load,
	output logic                      o_irq
);
	import iirq_pkg::*;

	generate
		if (TX_CTX < 1 || TX_CTX > 32 || RX_CHN < 1 || RX_CHN > 32
			|| ADDR_W < `IIRQ_OFF_W) begin : g_bad_param
			$error("iirq_top: channel counts must be 1..32 and ADDR_W at least 8");
		end
	endgenerate

	iirq_sel_t                sel;
	logic                     hi_zero;
	logic                     acc;
	logic                     wr;
	logic                     rd_setup;
	iirq_word_t               rd_mux;
	iirq_word_t               rdata_reg;
	logic                     hw_evt;
	logic [`IIRQ_BW_W-1:0]    bw_reg;
	iirq_word_t               chan_hi_reg;
	iirq_word_t               chan_lo_reg;
	logic [`IIRQ_BW_W-1:0]    bw_csr_reg;
	iirq_word_t               chan_hi_csr_reg;
	iirq_word_t               chan_lo_csr_reg;
	logic                     load_reg;
	logic                     rx_sum_next;
	logic                     tx_sum_next;
	logic                     rx_sum_reg;
	logic                     tx_sum_reg;
	logic [`IIRQ_STS_W-1:0]   sts_event;
	logic [`IIRQ_STS_W-1:0]   sts_value;
	logic [`IIRQ_STS_W-1:0]   sts_mask;

	// upper address bits must be zero so aliases never hit a register
	assign hi_zero = (i_paddr >> `IIRQ_OFF_W) == '0;

	always_comb begin
		sel = SEL_NONE;
		if (hi_zero) begin
			unique case (i_paddr[`IIRQ_OFF_W-1:0])
				`IIRQ_OFF_TXM_SET: sel = SEL_TXM_SET;
				`IIRQ_OFF_TXM_CLR: sel = SEL_TXM_CLR;
				`IIRQ_OFF_RXE_SET: sel = SEL_RXE_SET;
				`IIRQ_OFF_RXE_CLR: sel = SEL_RXE_CLR;
				`IIRQ_OFF_RXM_SET: sel = SEL_RXM_SET;
				`IIRQ_OFF_RXM_CLR: sel = SEL_RXM_CLR;
				`IIRQ_OFF_BW:      sel = SEL_BW;
				`IIRQ_OFF_CHAN_HI: sel = SEL_CHAN_HI;
				`IIRQ_OFF_CHAN_LO: sel = SEL_CHAN_LO;
				`IIRQ_OFF_STS:     sel = SEL_STS;
				`IIRQ_OFF_MSK:     sel = SEL_MSK;
				default:           sel = SEL_NONE;
			endcase
		end
	end

	// zero wait states: every access phase completes in its first cycle
	assign acc      = i_psel & i_penable;
	assign wr       = acc & i_pwrite;
	assign rd_setup = i_psel & ~i_penable & ~i_pwrite;
	assign o_pready  = 1'b1;
	assign o_pslverr = acc & (sel == SEL_NONE);

	iirq_sc_if #(.W(TX_CTX)) txm_if ();
	iirq_sc_if #(.W(RX_CHN)) rxm_if ();
	iirq_sc_if #(.W(RX_CHN)) rxe_if ();

	assign txm_if.set_we = wr & (sel == SEL_TXM_SET);
	assign txm_if.clr_we = wr & (sel == SEL_TXM_CLR);
	assign txm_if.wdata  = i_pwdata[TX_CTX-1:0];
	assign rxm_if.set_we = wr & (sel == SEL_RXM_SET);
	assign rxm_if.clr_we = wr & (sel == SEL_RXM_CLR);
	assign rxm_if.wdata  = i_pwdata[RX_CHN-1:0];
	assign rxe_if.set_we = wr & (sel == SEL_RXE_SET);
	assign rxe_if.clr_we = wr & (sel == SEL_RXE_CLR);
	assign rxe_if.wdata  = i_pwdata[RX_CHN-1:0];

	iirq_sc_bank #(.W(TX_CTX), .HW_EDGE(1'b0)) u_tx_mask (
		.i_clk      (i_ref_clk),
		.i_reset    (i_reset),
		.bus        (txm_if),
		.i_hw_level ('0)
	);

	iirq_sc_bank #(.W(RX_CHN), .HW_EDGE(1'b0)) u_rx_mask (
		.i_clk      (i_ref_clk),
		.i_reset    (i_reset),
		.bus        (rxm_if),
		.i_hw_level ('0)
	);

	// each context line is its descriptor-completion interrupt; only its rising edge counts
	iirq_sc_bank #(.W(RX_CHN), .HW_EDGE(1'b1)) u_rx_event (
		.i_clk      (i_ref_clk),
		.i_reset    (i_reset),
		.bus        (rxe_if),
		.i_hw_level (i_rx_ctx_irq)
	);

	always_comb begin
		rd_mux = '0;
		unique case (sel)
			SEL_TXM_SET, SEL_TXM_CLR: rd_mux[TX_CTX-1:0] = txm_if.value;
			SEL_RXM_SET, SEL_RXM_CLR: rd_mux[RX_CHN-1:0] = rxm_if.value;
			SEL_RXE_SET: rd_mux[RX_CHN-1:0] = rxe_if.value;
			SEL_RXE_CLR: rd_mux[RX_CHN-1:0] = rxe_if.value & rxm_if.value;
			SEL_BW:      rd_mux[`IIRQ_BW_W-1:0] = bw_reg;
			SEL_CHAN_HI: rd_mux = chan_hi_reg;
			SEL_CHAN_LO: rd_mux = chan_lo_reg;
			SEL_STS:     rd_mux[`IIRQ_STS_W-1:0] = sts_value;
			SEL_MSK:     rd_mux[`IIRQ_STS_W-1:0] = sts_mask;
			SEL_NONE:    rd_mux = '0;
		endcase
	end

	// read data is caught in the setup cycle so it comes from a flip-flop in the access cycle
	always_ff @(posedge i_ref_clk) begin
		if (i_reset) rdata_reg <= '0;
		else if (rd_setup) rdata_reg <= rd_mux;
	end
	assign o_prdata = rdata_reg;

	// hardware-class resets restore defaults; a bus reset only reloads the CSRs
	assign hw_evt = i_soft_reset | i_global_reset_pin | i_power_reset_pin | i_fund_reset;

	always_ff @(posedge i_ref_clk) begin
		if (i_reset || hw_evt) begin
			bw_reg      <= `IIRQ_BW_RST;
			chan_hi_reg <= `IIRQ_CHAN_RST;
			chan_lo_reg <= `IIRQ_CHAN_RST;
		end else if (wr) begin
			if (sel == SEL_BW) bw_reg <= i_pwdata[`IIRQ_BW_W-1:0];
			if (sel == SEL_CHAN_HI) chan_hi_reg <= i_pwdata;
			if (sel == SEL_CHAN_LO) chan_lo_reg <= i_pwdata;
		end
	end

	// the copy after a hardware-class reset carries the defaults, matching the field
	always_ff @(posedge i_ref_clk) begin
		if (i_reset || hw_evt) begin
			bw_csr_reg      <= `IIRQ_BW_RST;
			chan_hi_csr_reg <= `IIRQ_CHAN_RST;
			chan_lo_csr_reg <= `IIRQ_CHAN_RST;
		end else if (i_bus_reset) begin
			bw_csr_reg      <= bw_reg;
			chan_hi_csr_reg <= chan_hi_reg;
			chan_lo_csr_reg <= chan_lo_reg;
		end
	end

	always_ff @(posedge i_ref_clk) begin
		if (i_reset) load_reg <= 1'b1;
		else load_reg <= hw_evt | i_bus_reset;
	end

	assign o_bw_available_csr  = bw_csr_reg;
	assign o_chan_avail_hi_csr = chan_hi_csr_reg;
	assign o_chan_avail_lo_csr = chan_lo_csr_reg;
	assign o_csr_load          = load_reg;

	// bit i of the transmit mask gates bit i of the transmit events
	assign tx_sum_next = |(i_tx_event_flags & txm_if.value);
	assign rx_sum_next = |(rxe_if.value & rxm_if.value);

	always_ff @(posedge i_ref_clk) begin
		if (i_reset) begin
			rx_sum_reg <= 1'b0;
			tx_sum_reg <= 1'b0;
		end else begin
			rx_sum_reg <= rx_sum_next;
			tx_sum_reg <= tx_sum_next;
		end
	end

	assign o_iso_receive_summary_event  = rx_sum_reg;
	assign o_iso_transmit_summary_event = tx_sum_reg;
	assign o_tx_irq_mask                = txm_if.value;

	always_comb begin
		sts_event = '0;
		sts_event[`IIRQ_STS_RX]   = rx_sum_next & ~rx_sum_reg;
		sts_event[`IIRQ_STS_TX]   = tx_sum_next & ~tx_sum_reg;
		sts_event[`IIRQ_STS_LOAD] = hw_evt | i_bus_reset;
	end

	// only the bits the reader was shown are cleared, so a late event stays pending
	iirq_irq_status #(.W(`IIRQ_STS_W)) u_status (
		.i_clk        (i_ref_clk),
		.i_reset      (i_reset),
		.i_event      (sts_event),
		.i_rd_clear   (acc & ~i_pwrite & (sel == SEL_STS)),
		.i_clear_bits (rdata_reg[`IIRQ_STS_W-1:0]),
		.i_mask_we    (wr & (sel == SEL_MSK)),
		.i_mask_wdata (i_pwdata[`IIRQ_STS_W-1:0]),
		.o_status     (sts_value),
		.o_mask       (sts_mask),
		.o_irq        (o_irq)
	);

	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (i_reset);

	logic [RX_CHN-1:0] chk_rx_prev;
	always_ff @(posedge i_ref_clk) begin
		if (i_reset) chk_rx_prev <= '0;
		else chk_rx_prev <= i_rx_ctx_irq;
	end

	rx_edge_set_a: assert property (
		(i_rx_ctx_irq & ~chk_rx_prev) != '0
		|=> (rxe_if.value & $past(i_rx_ctx_irq & ~chk_rx_prev))
			== $past(i_rx_ctx_irq & ~chk_rx_prev))
		else $error("rising completion line did not set its flag");

	rx_set_write_a: assert property (
		wr && sel == SEL_RXE_SET
		|=> (rxe_if.value & $past(i_pwdata[RX_CHN-1:0])) == $past(i_pwdata[RX_CHN-1:0]))
		else $error("set write did not raise receive flags");

	rx_clear_write_a: assert property (
		wr && sel == SEL_RXE_CLR && (i_rx_ctx_irq & ~chk_rx_prev) == '0
		|=> (rxe_if.value & $past(i_pwdata[RX_CHN-1:0])) == '0)
		else $error("clear write left a receive flag set");

	rx_and_read_a: assert property (
		rd_setup && sel == SEL_RXE_CLR
		|=> o_prdata[RX_CHN-1:0] == $past(rxe_if.value & rxm_if.value))
		else $error("clear address read is not events AND mask");

	mask_read_same_a: assert property (
		rd_setup && (sel == SEL_RXM_SET || sel == SEL_RXM_CLR)
		|=> o_prdata[RX_CHN-1:0] == $past(rxm_if.value))
		else $error("receive mask read returned wrong value");

	tx_mask_read_a: assert property (
		rd_setup && (sel == SEL_TXM_SET || sel == SEL_TXM_CLR)
		|=> o_prdata[TX_CTX-1:0] == $past(txm_if.value))
		else $error("transmit mask read returned wrong value");

	rx_high_zero_a: assert property (
		rd_setup && (sel == SEL_RXE_SET || sel == SEL_RXE_CLR)
		|=> (o_prdata >> RX_CHN) == '0)
		else $error("receive event upper bits not zero");

	bw_upper_zero_a: assert property (
		rd_setup && sel == SEL_BW |=> (o_prdata >> `IIRQ_BW_W) == '0)
		else $error("bandwidth upper bits not zero");

	bus_keep_init_a: assert property (
		i_bus_reset && !hw_evt && !wr |=> $stable(bw_reg) && $stable(chan_lo_reg))
		else $error("bus reset disturbed an initial value");

	csr_copy_a: assert property (
		i_bus_reset && !hw_evt
		|=> o_csr_load && o_bw_available_csr == $past(bw_reg)
			&& o_chan_avail_hi_csr == $past(chan_hi_reg)
			&& o_chan_avail_lo_csr == $past(chan_lo_reg))
		else $error("bus reset did not copy initial values");

	hw_default_a: assert property (
		hw_evt |=> chan_hi_reg == `IIRQ_CHAN_RST && chan_lo_reg == `IIRQ_CHAN_RST
			&& bw_reg == `IIRQ_BW_RST ##1 o_chan_avail_hi_csr == `IIRQ_CHAN_RST)
		else $error("hardware reset did not restore defaults");

	rx_mask_reset_a: assert property (@(posedge i_ref_clk)
		$fell(i_reset) |-> rxm_if.value == '0 && txm_if.value == '0)
		else $error("masks not zero after reset");

	summary_a: assert property (
		##1 o_iso_receive_summary_event == $past(rx_sum_next)
			&& o_iso_transmit_summary_event == $past(tx_sum_next))
		else $error("summary event does not follow masked events");

	irq_follow_a: assert property (
		rx_sum_next && !rx_sum_reg && sts_mask[`IIRQ_STS_RX] && !wr |=> o_irq)
		else $error("unmasked receive summary did not raise the interrupt");

	tx_mask_set_a: assert property (
		wr && sel == SEL_TXM_SET
		|=> (txm_if.value & $past(i_pwdata[TX_CTX-1:0])) == $past(i_pwdata[TX_CTX-1:0]))
		else $error("set write did not raise transmit mask bits");

	tx_mask_clear_a: assert property (
		wr && sel == SEL_TXM_CLR
		|=> (txm_if.value & $past(i_pwdata[TX_CTX-1:0])) == '0)
		else $error("clear write left a transmit mask bit set");

	rx_mask_set_a: assert property (
		wr && sel == SEL_RXM_SET
		|=> (rxm_if.value & $past(i_pwdata[RX_CHN-1:0])) == $past(i_pwdata[RX_CHN-1:0]))
		else $error("set write did not raise receive mask bits");

	rx_mask_clear_a: assert property (
		wr && sel == SEL_RXM_CLR
		|=> (rxm_if.value & $past(i_pwdata[RX_CHN-1:0])) == '0)
		else $error("clear write left a receive mask bit set");

	status_clear_a: assert property (
		acc && !i_pwrite && sel == SEL_STS && sts_event == '0
		|=> (sts_value & $past(rdata_reg[`IIRQ_STS_W-1:0])) == '0)
		else $error("status read did not clear the bits it returned");

	csr_load_a: assert property (
		hw_evt || i_bus_reset |=> o_csr_load)
		else $error("reset event did not raise the load strobe");

	rx_edge_c: cover property ((i_rx_ctx_irq & ~chk_rx_prev) != '0 ##1 rx_sum_reg ##1 o_irq);
	bus_copy_c: cover property (i_bus_reset ##1 o_csr_load);
	rx_clear_c: cover property (wr && sel == SEL_RXE_CLR && rxe_if.value != '0);
	slverr_c: cover property (o_pslverr);
	hw_load_c: cover property (hw_evt ##1 o_csr_load);
endmodule // iirq_top

// [dv/iirq_top_tb_top.sv]
// Purpose: self-checking bench of the iso interrupt and init register slice
// Assumes: APB master tasks below; pready may stretch, so every wait is bounded
// Notes:   expectations come from the register layout, never from design outputs
`timescale 1ns/1ps
`include "iirq_regs.svh"
module iirq_top_tb_top;
	import iirq_pkg::*;
	logic             i_ref_clk;
	logic             i_reset;
	logic [3:0]       hw_rst;
	logic             i_bus_reset;
	logic             i_psel;
	logic             i_penable;
	logic             i_pwrite;
	logic [7:0]       i_paddr;
	iirq_word_t       i_pwdata;
	iirq_word_t       o_prdata;
	logic             o_pready;
	logic             o_pslverr;
	logic [3:0]       i_rx_ctx_irq;
	logic [7:0]       i_tx_event_flags;
	logic [7:0]       o_tx_irq_mask;
	logic             o_rx_sum;
	logic             o_tx_sum;
	logic [12:0]      o_bw_csr;
	iirq_word_t       o_hi_csr;
	iirq_word_t       o_lo_csr;
	logic             o_irq;
	logic             o_csr_load;
	iirq_word_t       rd;
	logic             err;
	int               bad_count;
	int               checks;

	iirq_top u_dut (
		.i_ref_clk(i_ref_clk), .i_reset(i_reset), .i_soft_reset(hw_rst[0]),
		.i_global_reset_pin(hw_rst[1]), .i_power_reset_pin(hw_rst[2]),
		.i_fund_reset(hw_rst[3]), .i_bus_reset(i_bus_reset), .i_psel(i_psel),
		.i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
		.i_pwdata(i_pwdata), .o_prdata(o_prdata), .o_pready(o_pready),
		.o_pslverr(o_pslverr), .i_rx_ctx_irq(i_rx_ctx_irq),
		.i_tx_event_flags(i_tx_event_flags), .o_tx_irq_mask(o_tx_irq_mask),
		.o_iso_receive_summary_event(o_rx_sum), .o_iso_transmit_summary_event(o_tx_sum),
		.o_bw_available_csr(o_bw_csr), .o_chan_avail_hi_csr(o_hi_csr),
		.o_chan_avail_lo_csr(o_lo_csr), .o_csr_load(o_csr_load), .o_irq(o_irq)
	);

	initial begin
		i_ref_clk = 1'b0;
		forever #10 i_ref_clk = ~i_ref_clk;
	end

	task automatic wrap_up();
		$display("checks %0d bad_count %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("ERROR %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	// one transfer; the request stands until pready is seen high at an edge
	task automatic apb(input logic wr, input logic [7:0] a, input iirq_word_t d);
		int n;
		@(posedge i_ref_clk);
		i_psel <= 1'b1;
		i_penable <= 1'b0;
		i_pwrite <= wr;
		i_paddr <= a;
		i_pwdata <= d;
		@(posedge i_ref_clk);
		i_penable <= 1'b1;
		n = 0;
		do begin
			@(posedge i_ref_clk);
			n++;
		end while (o_pready !== 1'b1 && n < 64);
		if (o_pready !== 1'b1) begin
			bad_count++;
			$display("ERROR pready timeout");
			wrap_up();
		end
		rd = o_prdata;
		err = o_pslverr;
		i_psel <= 1'b0;
		i_penable <= 1'b0;
	endtask

	task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0000_0000);
		chk(nm, rd, exp);
	endtask

	// sample just after an edge has landed
	task automatic settle(input int n);
		repeat (n) @(posedge i_ref_clk);
		#1;
	endtask

	task automatic pulse(input int which, input logic [3:0] v);
		@(posedge i_ref_clk);
		if (which == 0) i_rx_ctx_irq <= v;
		else if (which == 1) hw_rst <= v;
		else i_bus_reset <= v[0];
		@(posedge i_ref_clk);
		i_rx_ctx_irq <= 4'h0;
		hw_rst <= 4'h0;
		i_bus_reset <= 1'b0;
	endtask

	initial begin
		bad_count = 0;
		checks = 0;
		i_reset = 1'b1;
		hw_rst = 4'h0;
		i_bus_reset = 1'b0;
		i_psel = 1'b0;
		i_penable = 1'b0;
		i_pwrite = 1'b0;
		i_paddr = 8'h00;
		i_pwdata = 32'h0000_0000;
		i_rx_ctx_irq = 4'h0;
		i_tx_event_flags = 8'h00;
		repeat (2) @(posedge i_ref_clk);
		i_reset <= 1'b0;
		settle(1);
		chk("bw csr rst", {19'h0, o_bw_csr}, 32'h0000_1333);
		chk("hi csr rst", o_hi_csr, 32'hffff_ffff);
		chk("lo csr rst", o_lo_csr, 32'hffff_ffff);
		rchk("rxm set rst", `IIRQ_OFF_RXM_SET, 32'h0000_0000);
		rchk("rxm clr rst", `IIRQ_OFF_RXM_CLR, 32'h0000_0000);
		rchk("bw rst", `IIRQ_OFF_BW, 32'h0000_1333);
		rchk("hi rst", `IIRQ_OFF_CHAN_HI, 32'hffff_ffff);
		rchk("lo rst", `IIRQ_OFF_CHAN_LO, 32'hffff_ffff);
		// transmit mask: set, partial clear, zero write, reads at both addresses
		apb(1'b1, `IIRQ_OFF_TXM_SET, 32'hffff_ffff);
		apb(1'b1, `IIRQ_OFF_TXM_CLR, 32'h0000_000f);
		apb(1'b1, `IIRQ_OFF_TXM_CLR, 32'h0000_0000);
		rchk("txm set", `IIRQ_OFF_TXM_SET, 32'h0000_00f0);
		rchk("txm clr", `IIRQ_OFF_TXM_CLR, 32'h0000_00f0);
		chk("txm port", {24'h0, o_tx_irq_mask}, 32'h0000_00f0);
		i_tx_event_flags <= 8'h80;
		settle(2);
		chk("tx sum on", {31'h0, o_tx_sum}, 32'h1);
		chk("tx cause", {24'h0, i_tx_event_flags & o_tx_irq_mask}, 32'h0000_0080);
		@(posedge i_ref_clk);
		i_tx_event_flags <= 8'h01;
		settle(2);
		chk("tx sum masked", {31'h0, o_tx_sum}, 32'h0);
		// receive events: edge sets once, only write 1 at clear removes
		pulse(0, 4'h4);
		settle(2);
		rchk("rxe edge", `IIRQ_OFF_RXE_SET, 32'h0000_0004);
		apb(1'b1, `IIRQ_OFF_RXE_CLR, 32'h0000_0000);
		apb(1'b1, `IIRQ_OFF_RXE_SET, 32'h0000_0000);
		rchk("rxe zero wr", `IIRQ_OFF_RXE_SET, 32'h0000_0004);
		apb(1'b1, `IIRQ_OFF_RXE_CLR, 32'h0000_0004);
		@(posedge i_ref_clk);
		i_rx_ctx_irq <= 4'h2;
		settle(2);
		apb(1'b1, `IIRQ_OFF_RXE_CLR, 32'h0000_0002);
		settle(3);
		rchk("rxe level once", `IIRQ_OFF_RXE_SET, 32'h0000_0000);
		i_rx_ctx_irq <= 4'h0;
		apb(1'b1, `IIRQ_OFF_RXE_SET, 32'hffff_ffff);
		rchk("rxe width", `IIRQ_OFF_RXE_SET, 32'h0000_000f);
		apb(1'b1, `IIRQ_OFF_RXM_SET, 32'h0000_0003);
		rchk("rxm clr rd", `IIRQ_OFF_RXM_CLR, 32'h0000_0003);
		rchk("rxe and", `IIRQ_OFF_RXE_CLR, 32'h0000_0003);
		rchk("rxe raw", `IIRQ_OFF_RXE_SET, 32'h0000_000f);
		settle(1);
		chk("rx sum on", {31'h0, o_rx_sum}, 32'h1);
		rchk("rx cause", `IIRQ_OFF_RXE_CLR, 32'h0000_0003);
		apb(1'b1, `IIRQ_OFF_RXE_CLR, 32'h0000_0003);
		settle(2);
		chk("rx sum off", {31'h0, o_rx_sum}, 32'h0);
		// interrupt line: masked, unmasked, cleared by reading status
		apb(1'b1, `IIRQ_OFF_MSK, 32'h0000_0000);
		apb(1'b0, `IIRQ_OFF_STS, 32'h0000_0000);
		pulse(0, 4'h1);
		settle(4);
		chk("irq masked", {31'h0, o_irq}, 32'h0);
		apb(1'b1, `IIRQ_OFF_MSK, 32'h0000_0001);
		settle(2);
		chk("irq on", {31'h0, o_irq}, 32'h1);
		rchk("sts", `IIRQ_OFF_STS, 32'h0000_0001);
		settle(2);
		chk("irq cleared", {31'h0, o_irq}, 32'h0);
		rchk("msk", `IIRQ_OFF_MSK, 32'h0000_0001);
		apb(1'b1, 8'h50, 32'h1234_5678);
		chk("unmapped err", {31'h0, err}, 32'h1);
		rchk("unmapped rd", 8'h50, 32'h0000_0000);
		chk("unmapped rd err", {31'h0, err}, 32'h1);
		// init registers survive a bus reset and are copied by it
		apb(1'b1, `IIRQ_OFF_BW, 32'hffff_e5a5);
		apb(1'b1, `IIRQ_OFF_CHAN_HI, 32'h1357_9bdf);
		apb(1'b1, `IIRQ_OFF_CHAN_LO, 32'h0246_8ace);
		pulse(2, 4'h1);
		#1;
		chk("csr load", {31'h0, o_csr_load}, 32'h1);
		settle(1);
		chk("csr load end", {31'h0, o_csr_load}, 32'h0);
		chk("bw csr bus", {19'h0, o_bw_csr}, 32'h0000_05a5);
		chk("hi csr bus", o_hi_csr, 32'h1357_9bdf);
		chk("lo csr bus", o_lo_csr, 32'h0246_8ace);
		rchk("bw keep", `IIRQ_OFF_BW, 32'h0000_05a5);
		rchk("hi keep", `IIRQ_OFF_CHAN_HI, 32'h1357_9bdf);
		rchk("lo keep", `IIRQ_OFF_CHAN_LO, 32'h0246_8ace);
		// each hardware-class reset restores defaults and reloads the copies
		for (int k = 0; k < 4; k++) begin
			apb(1'b1, `IIRQ_OFF_BW, 32'h0000_0abc);
			apb(1'b1, `IIRQ_OFF_CHAN_LO, 32'h0000_0000);
			pulse(1, 4'h1 << k);
			settle(2);
			chk("bw csr hw", {19'h0, o_bw_csr}, 32'h0000_1333);
			chk("lo csr hw", o_lo_csr, 32'hffff_ffff);
			rchk("bw hw", `IIRQ_OFF_BW, 32'h0000_1333);
			rchk("lo hw", `IIRQ_OFF_CHAN_LO, 32'hffff_ffff);
		end
		rchk("hi hw", `IIRQ_OFF_CHAN_HI, 32'hffff_ffff);
		wrap_up();
	end
endmodule // iirq_top_tb_top
